// [hw/qbx_pkg.sv]
package qbx_pkg;

    // slave address is this fixed prefix followed by the three select pins
    localparam logic [3:0] ADDR_PREFIX = 4'h4;
    // reserved addresses that must never be acknowledged
    localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
    localparam logic [6:0] DEV_ID_ADDR = 7'h7c;

    // power-on values: pins high, strong pull-ups off
    localparam logic [15:0] LATCH_RST = 16'hffff;
    localparam logic [15:0] PULLUP_RST = 16'h0000;

    // bits per serial byte, as seen by the bit counter
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // core cycles, after the clearing cycle itself, during which a cleared port ignores pin changes
    localparam logic [2:0] CLR_CYCLES = 3'h4;

    // serial-bus slave states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_DATA,
        ST_WR_ACK,
        ST_RD_DATA,
        ST_RD_ACK
    } qbx_state_e;

    // one received data byte and the port it belongs to
    typedef struct packed {
        logic hi;
        logic [7:0] data;
    } qbx_wr_s;

endpackage

// [hw/qbx_top.sv]
module qbx_top
#(
    parameter logic [2:0] CLR_HOLD = qbx_pkg::CLR_CYCLES // pin-change blanking after a clear
)
(
    input wire logic clk_in, // core clock, 125 MHz
    input wire logic rstn_in, // synchronous reset, active low
    input wire logic link_clk_in, // serial-link sampling clock
    input wire logic scl_in, // serial clock pin
    input wire logic sda_in, // serial data pin level
    output logic sda_out, // serial data drive value
    output logic sda_oe_out, // serial data pull-down enable
    input wire logic [2:0] addr_select_pins_in, // address select pins
    input wire logic [7:0] low_port_pins_in, // low port pin levels
    output logic [7:0] low_port_pins_out, // low port drive value
    output logic [7:0] low_port_pins_oe_out, // low port sink enable
    input wire logic [7:0] high_port_pins_in, // high port pin levels
    output logic [7:0] high_port_pins_out, // high port drive value
    output logic [7:0] high_port_pins_oe_out, // high port sink enable
    output logic [15:0] transient_strong_pullup_out, // strong pull-up enables
    output logic int_out, // interrupt drive value
    output logic int_oe_out // interrupt pull-down enable
);
    import qbx_pkg::*;

    // byte of a 16-bit word selected by port
    function automatic logic [7:0] pick_byte(input logic [15:0] word, input logic hi);
        pick_byte = hi ? word[15:8] : word[7:0];
    endfunction

    // address match, with the reserved patterns refused outright
    function automatic logic addr_ok(input logic [6:0] a, input logic [2:0] sel);
        addr_ok = (a == {ADDR_PREFIX, sel}) && (a != GEN_CALL_ADDR) && (a != DEV_ID_ADDR);
    endfunction

    // link domain declarations
    logic [1:0] lrst_q;
    logic lrstn;
    logic scl_m_q, scl_s_q, scl_p_q;
    logic sda_m_q, sda_s_q, sda_p_q;
    logic [2:0] addr_m_q, addr_s_q;
    logic rack_m_q, rack_s_q, rack_d_q;
    logic scl_rise, scl_fall, start_det, stop_det, rd_ack_evt;
    qbx_state_e st_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q, tx_q;
    logic rw_q, port_hi_q, ack_seen_q, rd_wait_q, rd_ready_q, sda_oe_q;
    logic wr_tog_q, rd_tog_q, fall_tog_q, rd_port_q;
    qbx_wr_s wr_req_q;

    // core domain declarations
    logic [15:0] pins_m_q, pins_s_q;
    logic [2:0] tog_m_q, tog_s_q, tog_d_q;
    logic wr_evt, rd_evt, fall_evt;
    logic [15:0] port_latch_q, strong_q, strong_d, ref_q, clr_mask;
    logic [7:0] rd_byte_q;
    logic rd_ack_tog_q, int_oe_q;
    logic [2:0] clr_lo_q, clr_hi_q;
    logic clr_lo_now, clr_hi_now;

    // reset release carried into the link domain
    always_ff @(posedge link_clk_in)
    begin
        lrst_q <= {lrst_q[0], rstn_in};
    end
    assign lrstn = lrst_q[1];

    // pin synchronisers; the third stage of scl and sda feeds edge detection
    always_ff @(posedge link_clk_in)
    begin
        if (!lrstn)
        begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
            addr_m_q <= 3'h0;
            addr_s_q <= 3'h0;
            rack_m_q <= 1'b0;
            rack_s_q <= 1'b0;
            rack_d_q <= 1'b0;
        end
        else
        begin
            scl_m_q <= scl_in;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= sda_in;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
            addr_m_q <= addr_select_pins_in;
            addr_s_q <= addr_m_q;
            rack_m_q <= rd_ack_tog_q;
            rack_s_q <= rack_m_q;
            rack_d_q <= rack_s_q;
        end
    end

    assign scl_rise = scl_s_q & ~scl_p_q;
    assign scl_fall = ~scl_s_q & scl_p_q;
    assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
    assign rd_ack_evt = rack_s_q ^ rack_d_q;

    // serial-bus slave; sda is only changed while scl is low, except by start/stop
    // bus state machine reset
    always_ff @(posedge link_clk_in)
    begin
        if (!lrstn)
        begin
            st_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            rw_q <= 1'b0;
            port_hi_q <= 1'b0;
            ack_seen_q <= 1'b0;
            rd_wait_q <= 1'b0;
            rd_ready_q <= 1'b0;
            sda_oe_q <= 1'b0;
            wr_tog_q <= 1'b0;
            rd_tog_q <= 1'b0;
            rd_port_q <= 1'b0;
            wr_req_q <= '0;
        end
        else if (start_det)
        begin
            st_q <= ST_ADDR;
            bit_cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
            rd_wait_q <= 1'b0;
        end
        else if (stop_det)
        begin
            st_q <= ST_IDLE;
            sda_oe_q <= 1'b0;
            rd_wait_q <= 1'b0;
        end
        else
        begin
            if (scl_rise && (st_q == ST_ADDR || st_q == ST_WR_DATA))
            begin
                shift_q <= {shift_q[6:0], sda_s_q};
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            unique case (st_q)
                ST_IDLE:
                begin
                    sda_oe_q <= 1'b0;
                end
                ST_ADDR:
                begin
                    if (scl_fall && bit_cnt_q == BYTE_BITS)
                    begin
                        bit_cnt_q <= 4'h0;
                        if (addr_ok(shift_q[7:1], addr_s_q))
                        begin
                            sda_oe_q <= 1'b1;
                            rw_q <= shift_q[0];
                            port_hi_q <= 1'b0;
                            st_q <= ST_ADDR_ACK;
                        end
                        else
                        begin
                            st_q <= ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK:
                begin
                    // first read byte requests low port
                    if (scl_rise && rw_q)
                    begin
                        rd_tog_q <= ~rd_tog_q;
                        rd_port_q <= 1'b0;
                        rd_ready_q <= 1'b0;
                    end
                    if (scl_fall)
                    begin
                        sda_oe_q <= 1'b0;
                        st_q <= rw_q ? ST_RD_DATA : ST_WR_DATA;
                        rd_wait_q <= rw_q;
                        bit_cnt_q <= 4'h0;
                    end
                end
                ST_WR_DATA:
                begin
                    if (scl_fall && bit_cnt_q == BYTE_BITS)
                    begin
                        sda_oe_q <= 1'b1;
                        wr_req_q <= '{hi: port_hi_q, data: shift_q};
                        bit_cnt_q <= 4'h0;
                        st_q <= ST_WR_ACK;
                    end
                end
                ST_WR_ACK:
                begin
                    if (scl_fall)
                    begin
                        sda_oe_q <= 1'b0;
                        wr_tog_q <= ~wr_tog_q;
                        port_hi_q <= ~port_hi_q;
                        st_q <= ST_WR_DATA;
                    end
                end
                ST_RD_DATA:
                begin
                    if (rd_wait_q)
                    begin
                        // hold bit 7 back until the core has answered
                        if (rd_ready_q)
                        begin
                            tx_q <= rd_byte_q;
                            sda_oe_q <= ~rd_byte_q[7];
                            rd_wait_q <= 1'b0;
                            rd_ready_q <= 1'b0;
                            bit_cnt_q <= 4'h0;
                        end
                    end
                    else
                    begin
                        if (scl_rise)
                        begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                        if (scl_fall)
                        begin
                            if (bit_cnt_q == BYTE_BITS)
                            begin
                                sda_oe_q <= 1'b0;
                                st_q <= ST_RD_ACK;
                            end
                            else
                            begin
                                tx_q <= {tx_q[6:0], 1'b0};
                                sda_oe_q <= ~tx_q[6];
                            end
                        end
                    end
                end
                ST_RD_ACK:
                begin
                    if (scl_rise)
                    begin
                        if (!sda_s_q)
                        begin
                            // next byte from the other port
                            ack_seen_q <= 1'b1;
                            port_hi_q <= ~port_hi_q;
                            rd_port_q <= ~port_hi_q;
                            rd_tog_q <= ~rd_tog_q;
                            rd_ready_q <= 1'b0;
                        end
                        else
                        begin
                            ack_seen_q <= 1'b0;
                            st_q <= ST_IDLE;
                        end
                    end
                    if (scl_fall && ack_seen_q)
                    begin
                        st_q <= ST_RD_DATA;
                        rd_wait_q <= 1'b1;
                    end
                end
            endcase
            // answer from the core; placed last so it wins over a clear
            if (rd_ack_evt)
            begin
                rd_ready_q <= 1'b1;
            end
        end
    end

    // every falling scl edge is reported to the core for the pull-up timer
    always_ff @(posedge link_clk_in)
    begin
        if (!lrstn)
        begin
            fall_tog_q <= 1'b0;
        end
        else if (scl_fall)
        begin
            fall_tog_q <= ~fall_tog_q;
        end
    end

    assign sda_out = 1'b0; // open drain: only ever pulls low
    assign sda_oe_out = sda_oe_q;

    // core domain logic

    // pin and toggle synchronisers into the core clock
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            pins_m_q <= LATCH_RST;
            pins_s_q <= LATCH_RST;
            tog_m_q <= 3'h0;
            tog_s_q <= 3'h0;
            tog_d_q <= 3'h0;
        end
        else
        begin
            pins_m_q <= {high_port_pins_in, low_port_pins_in};
            pins_s_q <= pins_m_q;
            tog_m_q <= {fall_tog_q, rd_tog_q, wr_tog_q};
            tog_s_q <= tog_m_q;
            tog_d_q <= tog_s_q;
        end
    end

    assign wr_evt = tog_s_q[0] ^ tog_d_q[0];
    assign rd_evt = tog_s_q[1] ^ tog_d_q[1];
    assign fall_evt = tog_s_q[2] ^ tog_d_q[2];

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            port_latch_q <= LATCH_RST;
        end
        else if (wr_evt)
        begin
            if (wr_req_q.hi)
            begin
                port_latch_q[15:8] <= wr_req_q.data;
            end
            else
            begin
                port_latch_q[7:0] <= wr_req_q.data;
            end
        end
    end

    // a write landing on the same scl fall that ends it keeps its pull-up on
    always_comb
    begin
        strong_d = fall_evt ? PULLUP_RST : strong_q;
        if (wr_evt)
        begin
            if (wr_req_q.hi)
            begin
                strong_d[15:8] = strong_d[15:8] | wr_req_q.data;
            end
            else
            begin
                strong_d[7:0] = strong_d[7:0] | wr_req_q.data;
            end
        end
    end

    // strong pull-up enables
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            strong_q <= PULLUP_RST;
        end
        else
        begin
            strong_q <= strong_d;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            rd_byte_q <= 8'h00;
            rd_ack_tog_q <= 1'b0;
        end
        else if (rd_evt)
        begin
            rd_byte_q <= pick_byte(pins_s_q, rd_port_q);
            rd_ack_tog_q <= ~rd_ack_tog_q;
        end
    end

    assign clr_lo_now = wr_evt | (rd_evt & ~rd_port_q) | (clr_lo_q != 3'h0);
    assign clr_hi_now = wr_evt | (rd_evt & rd_port_q) | (clr_hi_q != 3'h0);
    assign clr_mask = {{8{clr_hi_now}}, {8{clr_lo_now}}};

    // blanking counters; pins settle a few cycles after a latch change
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            clr_lo_q <= 3'h0;
            clr_hi_q <= 3'h0;
        end
        else
        begin
            if (wr_evt || (rd_evt && !rd_port_q))
            begin
                clr_lo_q <= CLR_HOLD;
            end
            else if (clr_lo_q != 3'h0)
            begin
                clr_lo_q <= clr_lo_q - 3'h1;
            end
            if (wr_evt || (rd_evt && rd_port_q))
            begin
                clr_hi_q <= CLR_HOLD;
            end
            else if (clr_hi_q != 3'h0)
            begin
                clr_hi_q <= clr_hi_q - 3'h1;
            end
        end
    end

    // reference follows pins only while clearing
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            ref_q <= LATCH_RST;
        end
        else
        begin
            ref_q <= (pins_s_q & clr_mask) | (ref_q & ~clr_mask);
        end
    end

    // interrupt while pins differ from reference
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            int_oe_q <= 1'b0;
        end
        else
        begin
            int_oe_q <= |((pins_s_q ^ ref_q) & ~clr_mask);
        end
    end

    // low sinks, high left to the weak source
    assign low_port_pins_out = 8'h00;
    assign high_port_pins_out = 8'h00;
    assign low_port_pins_oe_out = ~port_latch_q[7:0];
    assign high_port_pins_oe_out = ~port_latch_q[15:8];
    assign transient_strong_pullup_out = strong_q;
    assign int_out = 1'b0;
    assign int_oe_out = int_oe_q;

    // checks on what the block drives
    latch_update_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_evt |=> pick_byte(port_latch_q, $past(wr_req_q.hi)) == $past(wr_req_q.data))
        else $error("written byte did not reach its port latch");
    latch_reset_a: assert property (@(posedge clk_in)
        !rstn_in |=> port_latch_q == LATCH_RST && !int_oe_out)
        else $error("latches not high after reset");
    pullup_set_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_evt |=> (pick_byte(strong_q, $past(wr_req_q.hi)) & $past(wr_req_q.data)) == $past(wr_req_q.data))
        else $error("strong pull-up missing on written high");
    pullup_clear_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        fall_evt && !wr_evt |=> strong_q == PULLUP_RST)
        else $error("strong pull-up survived an scl fall");
    int_release_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        pins_s_q == ref_q |=> !int_oe_out)
        else $error("interrupt held with pins at reference");
    read_sample_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        rd_evt |=> rd_byte_q == pick_byte($past(pins_s_q), rd_port_q))
        else $error("read byte not sampled from pins");
    read_bytewise_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        rd_evt && !rd_port_q && !wr_evt && clr_hi_q == 3'h0 |=> ref_q[15:8] == $past(ref_q[15:8]))
        else $error("low read disturbed high port causes");
    write_clear_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_evt |-> ##1 !int_oe_out [*4])
        else $error("interrupt not released by write");
    ack_hold_a: assert property (@(posedge link_clk_in) disable iff (!lrstn)
        (st_q == ST_ADDR_ACK || st_q == ST_WR_ACK) && scl_s_q && !start_det && !stop_det |-> sda_oe_q)
        else $error("acknowledge not held during clock high");
    stop_idle_a: assert property (@(posedge link_clk_in) disable iff (!lrstn)
        stop_det && !start_det |=> st_q == ST_IDLE && !sda_oe_q)
        else $error("stop did not return slave to idle");
    nack_release_a: assert property (@(posedge link_clk_in) disable iff (!lrstn)
        st_q == ST_RD_ACK |-> !sda_oe_q)
        else $error("sda driven during master acknowledge");

    write_pair_c: cover property (@(posedge clk_in) disable iff (!rstn_in)
        wr_evt && !wr_req_q.hi ##[1:1000] wr_evt && wr_req_q.hi);
    read_pair_c: cover property (@(posedge clk_in) disable iff (!rstn_in)
        rd_evt && !rd_port_q ##[1:1000] rd_evt && rd_port_q);
    int_raise_c: cover property (@(posedge clk_in) disable iff (!rstn_in) $rose(int_oe_out));
    master_nack_c: cover property (@(posedge link_clk_in) disable iff (!lrstn)
        st_q == ST_RD_ACK && scl_rise && sda_s_q);

endmodule

// [bench/qbx_master.sv]
// serial master plus pacing; it stands on the far side of the serial pins
module qbx_master
(
    input wire logic clk_in, // pacing clock
    input wire logic sda_oe_in, // device sinks data line
    output logic scl_out, // serial clock
    output logic sda_out // resolved data wire
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sda_low = 1'b0;
    initial scl_out = 1'b1;
    // pull-up wire: low while either party sinks it
    assign sda_out = !(sda_low || sda_oe_in);
    // wait n core edges, then move both lines together
    task seq(input int n, input logic c, input logic d);
        repeat (n) @(posedge clk_in) #1;
        scl_out = c;
        sda_low = d;
    endtask
    // start from idle or as a repeated start
    task start();
        seq(18, scl_out, 1'b0);
        seq(20, 1'b1, 1'b0);
        seq(20, 1'b1, 1'b1);
        seq(20, 1'b0, 1'b1);
    endtask
    // stop leaves both lines idle high
    task stop();
        seq(18, 1'b0, 1'b1);
        seq(20, 1'b1, 1'b1);
        seq(20, 1'b1, 1'b0);
        seq(20, 1'b1, 1'b0);
    endtask
    // data moves only while the clock is low
    task bit_io(input logic b, output logic r);
        seq(18, 1'b0, !b);
        seq(20, 1'b1, !b);
        repeat (8) @(posedge clk_in) #1;
        r = sda_out;
        seq(7, 1'b0, !b);
    endtask
    // ninth clock carries the acknowledge either way
    task xfer(input logic [7:0] d, input logic ack_bit, output logic [7:0] q, output logic r);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(ack_bit, r);
    endtask
endmodule

// [bench/qbx_top_tb_top.sv]
module qbx_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import qbx_pkg::*;
    logic clk_in = 1'b0;
    logic link_clk = 1'b0;
    logic rstn_in = 1'b0;
    logic scl, sda, sda_oe, int_oe, ack;
    logic [2:0] sel;
    logic [7:0] lo_oe, hi_oe, a, b, c, q0, q1;
    logic [15:0] spu;
    logic sda_drv, int_drv;
    logic [7:0] lo_drv, hi_drv;
    logic [15:0] ext_en = 16'h0000;
    logic [15:0] ext_val = 16'h0000;
    integer seed = 32'h847d_34a6;
    int errors = 0;
    int comparisons = 0;
    wire logic [15:0] pins = ~{hi_oe, lo_oe} & (~ext_en | ext_val);
    always #4 clk_in = ~clk_in;
    // link clock runs free, its phase unrelated to the core clock
    initial #1.7 forever #6 link_clk = ~link_clk;
    qbx_master qbx_master_inst (.clk_in(clk_in), .sda_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));
    qbx_top qbx_top_inst (.clk_in(clk_in), .rstn_in(rstn_in), .link_clk_in(link_clk), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_drv), .sda_oe_out(sda_oe), .addr_select_pins_in(sel),
        .low_port_pins_in(pins[7:0]), .low_port_pins_out(lo_drv), .low_port_pins_oe_out(lo_oe),
        .high_port_pins_in(pins[15:8]), .high_port_pins_out(hi_drv), .high_port_pins_oe_out(hi_oe),
        .transient_strong_pullup_out(spu), .int_out(int_drv), .int_oe_out(int_oe));
    // own address: fixed prefix then the select pins
    function automatic logic [6:0] own_addr(input logic [2:0] s);
        return {4'h4, s};
    endfunction
    // latched high pins read the external level, low ones read zero
    function automatic logic [15:0] exp_pins(input logic [15:0] lat, input logic [15:0] en, input logic [15:0] v);
        return lat & (~en | v);
    endfunction
    task chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            errors++;
        end
    endtask
    task settle();
        repeat (40) @(posedge clk_in) #1;
    endtask
    task send(input logic [7:0] d, input logic exp_r);
        qbx_master_inst.xfer(d, 1'b1, q1, ack);
        chk({15'h0000, ack}, {15'h0000, exp_r});
    endtask
    task wr_ones();
        qbx_master_inst.start();
        send({own_addr(sel), 1'b0}, 1'b0);
        send(8'hff, 1'b0);
        send(8'hff, 1'b0);
        qbx_master_inst.stop();
        settle();
    endtask
    task wrap_up();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // a hung handshake ends the run as a failure; about three times the expected run
    initial
    begin
        #400000;
        errors++;
        wrap_up();
    end
    initial
    begin
        sel = 3'($random(seed));
        repeat (12) @(posedge clk_in);
        #1 rstn_in = 1'b1;
        repeat (20) @(posedge clk_in) #1;
        chk({hi_oe, lo_oe}, 16'h0000);
        chk(spu, 16'h0000);
        chk({15'h0000, int_oe}, 16'h0000);
        // open-drain pins only ever pull low
        chk({hi_drv, lo_drv}, 16'h0000);
        chk({14'h0000, sda_drv, int_drv}, 16'h0000);
        // odd third byte overwrites low port; first pass uses all-zero corner
        for (int k = 0; k < 4; k++)
        begin
            a = 8'($random(seed));
            b = 8'($random(seed));
            c = (k == 0) ? 8'h00 : 8'($random(seed));
            qbx_master_inst.start();
            send({own_addr(sel), 1'b0}, 1'b0);
            send(a, 1'b0);
            send(b, 1'b0);
            send(c, 1'b0);
            qbx_master_inst.stop();
            settle();
            chk({hi_oe, lo_oe}, ~{b, c});
            chk(spu, {8'h00, c});
        end
        // mid-run reset returns latches and pull-ups to power-on state
        rstn_in = 1'b0;
        repeat (12) @(posedge clk_in);
        #1 rstn_in = 1'b1;
        settle();
        chk({hi_oe, lo_oe}, 16'h0000);
        chk(spu, 16'h0000);
        // reserved and foreign addresses get no acknowledge
        for (int k = 0; k < 3; k++)
        begin
            qbx_master_inst.start();
            send({(k == 0) ? 7'h00 : (k == 1) ? 7'h7c : own_addr(~sel), 1'b0}, 1'b1);
            qbx_master_inst.stop();
        end
        wr_ones();
        ext_en = 16'h0008;
        settle();
        chk({15'h0000, int_oe}, 16'h0001);
        ext_en = 16'h0000;
        settle();
        chk({15'h0000, int_oe}, 16'h0000);
        ext_en = 16'h0400;
        settle();
        // address-only write, then a repeated start turns it into a read
        qbx_master_inst.start();
        send({own_addr(sel), 1'b0}, 1'b0);
        qbx_master_inst.start();
        send({own_addr(sel), 1'b1}, 1'b0);
        qbx_master_inst.xfer(8'hff, 1'b1, q0, ack);
        qbx_master_inst.stop();
        settle();
        chk({8'h00, q0}, exp_pins(16'hffff, ext_en, ext_val) & 16'h00ff);
        chk({15'h0000, int_oe}, 16'h0001);
        chk({15'h0000, sda_oe}, 16'h0000);
        ext_en = {8'h04, 8'($random(seed))};
        ext_val = {8'h00, 8'($random(seed))};
        settle();
        qbx_master_inst.start();
        send({own_addr(sel), 1'b1}, 1'b0);
        qbx_master_inst.xfer(8'hff, 1'b0, q0, ack);
        qbx_master_inst.xfer(8'hff, 1'b1, q1, ack);
        qbx_master_inst.stop();
        settle();
        chk({q1, q0}, exp_pins(16'hffff, ext_en, ext_val));
        chk({15'h0000, int_oe}, 16'h0000);
        ext_en = 16'h0000;
        settle();
        chk({15'h0000, int_oe}, 16'h0001);
        wr_ones();
        chk({15'h0000, int_oe}, 16'h0000);
        wrap_up();
    end
endmodule
